// >>> mefs_consts.vh
// constants for the network controller error-status flag block
`ifndef MEFS_CONSTS_VH
`define MEFS_CONSTS_VH
// register select value of the main control/status register
`define MEFS_SEL_MAIN 2'h0
// bit positions inside the main control/status register
`define MEFS_BIT_ERR 15
`define MEFS_BIT_TX_BABBLE_FLAG 14
`define MEFS_BIT_COLLISION_TEST_ERROR 13
`define MEFS_BIT_MISS 12
`define MEFS_BIT_BUS_TIMEOUT_FLAG 11
`define MEFS_BIT_RINT 10
`define MEFS_BIT_TINT 9
`define MEFS_BIT_IDON 8
`define MEFS_BIT_IRQ_FLAG 7
`define MEFS_BIT_IRQ_ENABLE 6
`define MEFS_BIT_RXON 5
`define MEFS_BIT_TXON 4
`define MEFS_BIT_STOP 2
// babble threshold in bytes
`define MEFS_BABBLE_BYTES 1519
// timing figures in nanoseconds and the clock period
`define MEFS_CLK_NS 50
`define MEFS_COLLISION_TEST_ERROR_WAIT_NS 2000
`define MEFS_BUS_TIMEOUT_FLAG_WAIT_NS 25600
`endif

// >>> mefs_error_status.v
// error-status flags of the main control/status register
//
// Operation
// R1 - bit 15 is OR of four errors
// R2 - babble set at 1519 transmitted bytes
// R3 - transmitter never truncates frame itself
// R4 - babble set raises interrupt when enabled
// R5 - babble write-one clears; stop, reset clear
// R6 - collision missing 2 us after transmit
// R7 - transceiver pulses collision after transmit
// R8 - collision error write-one clear, stop clear
// R9 - missed packet on overflow without buffer
// R10 - missed frame writes no ring status
// R11 - missed packet raises interrupt when enabled
// R12 - missed packet write-one clear, stop clear
// R13 - ready absent 25.6 us sets memory error
// R14 - memory error stops receiver and transmitter
// R15 - memory error write-one clear, stop clear
// R16 - interrupt flag ORs six, excludes collision
// R17 - interrupt pin low when flag and enable
// R18 - host selects register zero first
// R19 - hardware set wins over write clear
`timescale 1ns/1ps
`default_nettype none
`include "mefs_consts.vh"
module mefs_error_status #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire I_CLK,
  input wire I_RESETN,
  // register ports
  input wire [1:0] I_REG_SELECT_PORT,
  input wire I_REG_WR,
  input wire I_REG_RD,
  input wire [15:0] I_REG_WDATA,
  output reg [15:0] O_REG_RDATA,
  // lower-order status and control from the rest of the controller
  input wire I_RX_INT,
  input wire I_TX_INT,
  input wire I_INIT_DONE,
  input wire I_RX_ON,
  input wire I_TX_ON,
  // transmit events
  input wire I_TX_BYTE,
  input wire I_TX_END,
  // transceiver collision pin
  input wire I_COLLISION,
  // receive events
  input wire I_RX_OVERFLOW,
  input wire I_RX_BUF_OWNED,
  // bus master cycle
  input wire I_BUS_ADDR_STROBE,
  input wire I_BUS_READY,
  // outputs
  output reg O_IRQ_N,
  output reg O_RX_KILL,
  output reg O_TX_KILL,
  output reg O_RING_STATUS_WR_EN,
  output reg O_STOP
);
  localparam [CNT_W-1:0] COLLISION_TEST_ERROR_CYC = `MEFS_COLLISION_TEST_ERROR_WAIT_NS / `MEFS_CLK_NS;
  localparam [CNT_W-1:0] BUS_TIMEOUT_FLAG_CYC = `MEFS_BUS_TIMEOUT_FLAG_WAIT_NS / `MEFS_CLK_NS;
  localparam [CNT_W-1:0] TX_BABBLE_FLAG_LIM = `MEFS_BABBLE_BYTES;

  // ==========================================================
  // input synchronisers
  // ==========================================================
  reg col_s1_ff, col_s2_ff, rdy_s1_ff, rdy_s2_ff;
  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      col_s1_ff <= 1'b0;
      col_s2_ff <= 1'b0;
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
    end else begin
      col_s1_ff <= I_COLLISION;
      col_s2_ff <= col_s1_ff;
      rdy_s1_ff <= I_BUS_READY;
      rdy_s2_ff <= rdy_s1_ff;
    end
  end

  // ==========================================================
  // host access decode
  // ==========================================================
  wire sel0 = (I_REG_SELECT_PORT == `MEFS_SEL_MAIN);
  wire wr0 = I_REG_WR && sel0;
  // writing stop clears the four error flags and the enable
  wire stop_set = wr0 && I_REG_WDATA[`MEFS_BIT_STOP];
  wire clr_tx_babble_flag = wr0 && I_REG_WDATA[`MEFS_BIT_TX_BABBLE_FLAG];
  wire clr_collision_test_error = wr0 && I_REG_WDATA[`MEFS_BIT_COLLISION_TEST_ERROR];
  wire clr_miss = wr0 && I_REG_WDATA[`MEFS_BIT_MISS];
  wire clr_bus_timeout_flag = wr0 && I_REG_WDATA[`MEFS_BIT_BUS_TIMEOUT_FLAG];

  // ==========================================================
  // event detection
  // ==========================================================
  reg [CNT_W-1:0] byte_cnt_ff, collision_test_error_cnt_ff, bus_timeout_flag_cnt_ff;
  reg collision_test_error_wait_ff, bus_timeout_flag_wait_ff;
  reg tx_babble_flag_ff, collision_test_error_ff, miss_ff, bus_timeout_flag_ff, irq_enable_ff, stop_ff;

  // R2 byte threshold; R3 no truncation, the count only observes
  wire set_tx_babble_flag = I_TX_BYTE && (byte_cnt_ff == TX_BABBLE_FLAG_LIM - 1'b1);
  // R6 collision window expiry
  wire set_collision_test_error = collision_test_error_wait_ff && !col_s2_ff && (collision_test_error_cnt_ff == COLLISION_TEST_ERROR_CYC - 1'b1);
  // R9 lost frame without a buffer
  wire set_miss = I_RX_OVERFLOW && !I_RX_BUF_OWNED;
  // R13 ready timeout
  wire set_bus_timeout_flag = bus_timeout_flag_wait_ff && !rdy_s2_ff && (bus_timeout_flag_cnt_ff == BUS_TIMEOUT_FLAG_CYC - 1'b1);

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      byte_cnt_ff <= {CNT_W{1'b0}};
      collision_test_error_cnt_ff <= {CNT_W{1'b0}};
      bus_timeout_flag_cnt_ff <= {CNT_W{1'b0}};
      collision_test_error_wait_ff <= 1'b0;
      bus_timeout_flag_wait_ff <= 1'b0;
    end else begin
      if (I_TX_END)
        byte_cnt_ff <= {CNT_W{1'b0}};
      else if (I_TX_BYTE && byte_cnt_ff != TX_BABBLE_FLAG_LIM)
        byte_cnt_ff <= byte_cnt_ff + 1'b1;
      // R7 collision pulse ends the wait
      if (I_TX_END) begin
        collision_test_error_wait_ff <= 1'b1;
        collision_test_error_cnt_ff <= {CNT_W{1'b0}};
      end else if (collision_test_error_wait_ff) begin
        if (col_s2_ff || set_collision_test_error)
          collision_test_error_wait_ff <= 1'b0;
        collision_test_error_cnt_ff <= collision_test_error_cnt_ff + 1'b1;
      end
      if (I_BUS_ADDR_STROBE) begin
        bus_timeout_flag_wait_ff <= 1'b1;
        bus_timeout_flag_cnt_ff <= {CNT_W{1'b0}};
      end else if (bus_timeout_flag_wait_ff) begin
        if (rdy_s2_ff || set_bus_timeout_flag)
          bus_timeout_flag_wait_ff <= 1'b0;
        bus_timeout_flag_cnt_ff <= bus_timeout_flag_cnt_ff + 1'b1;
      end
    end
  end

  // ==========================================================
  // sticky flags
  // ==========================================================
  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tx_babble_flag_ff <= 1'b0;
      collision_test_error_ff <= 1'b0;
      miss_ff <= 1'b0;
      bus_timeout_flag_ff <= 1'b0;
      irq_enable_ff <= 1'b0;
      stop_ff <= 1'b1;
    end else begin
      // R19 set wins over clear
      // R5 babble clear paths
      tx_babble_flag_ff <= set_tx_babble_flag | (tx_babble_flag_ff & ~clr_tx_babble_flag & ~stop_set);
      // R8 collision error clear paths
      collision_test_error_ff <= set_collision_test_error | (collision_test_error_ff & ~clr_collision_test_error & ~stop_set);
      // R12 missed packet clear paths
      miss_ff <= set_miss | (miss_ff & ~clr_miss & ~stop_set);
      // R15 memory error clear paths
      bus_timeout_flag_ff <= set_bus_timeout_flag | (bus_timeout_flag_ff & ~clr_bus_timeout_flag & ~stop_set);
      if (stop_set)
        irq_enable_ff <= 1'b0;
      else if (wr0)
        irq_enable_ff <= I_REG_WDATA[`MEFS_BIT_IRQ_ENABLE];
      if (stop_set)
        stop_ff <= 1'b1;
      else if (wr0 && I_REG_WDATA[1:0] != 2'h0)
        stop_ff <= 1'b0;
    end
  end

  // ==========================================================
  // summaries and outputs
  // ==========================================================
  // R1 error summary
  wire err = tx_babble_flag_ff | collision_test_error_ff | miss_ff | bus_timeout_flag_ff;
  // R16 interrupt flag, collision error excluded
  wire irq_flag = tx_babble_flag_ff | miss_ff | bus_timeout_flag_ff | I_RX_INT | I_TX_INT | I_INIT_DONE;
  reg [15:0] rd_word;
  always @* begin
    rd_word = 16'h0000;
    rd_word[`MEFS_BIT_ERR] = err;
    rd_word[`MEFS_BIT_TX_BABBLE_FLAG] = tx_babble_flag_ff;
    rd_word[`MEFS_BIT_COLLISION_TEST_ERROR] = collision_test_error_ff;
    rd_word[`MEFS_BIT_MISS] = miss_ff;
    rd_word[`MEFS_BIT_BUS_TIMEOUT_FLAG] = bus_timeout_flag_ff;
    rd_word[`MEFS_BIT_RINT] = I_RX_INT;
    rd_word[`MEFS_BIT_TINT] = I_TX_INT;
    rd_word[`MEFS_BIT_IDON] = I_INIT_DONE;
    rd_word[`MEFS_BIT_IRQ_FLAG] = irq_flag;
    rd_word[`MEFS_BIT_IRQ_ENABLE] = irq_enable_ff;
    rd_word[`MEFS_BIT_RXON] = I_RX_ON & ~bus_timeout_flag_ff;
    rd_word[`MEFS_BIT_TXON] = I_TX_ON & ~bus_timeout_flag_ff;
    rd_word[`MEFS_BIT_STOP] = stop_ff;
  end

  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_REG_RDATA <= 16'h0000;
      O_IRQ_N <= 1'b1;
      O_RX_KILL <= 1'b0;
      O_TX_KILL <= 1'b0;
      O_RING_STATUS_WR_EN <= 1'b1;
      O_STOP <= 1'b1;
    end else begin
      // other selects belong to neighbouring logic and read zero here
      O_REG_RDATA <= (I_REG_RD && sel0) ? rd_word : 16'h0000;
      // R4 R11 R17 interrupt pin low on flag and enable
      O_IRQ_N <= ~(irq_flag & irq_enable_ff);
      // R14 memory error shuts receiver and transmitter
      O_RX_KILL <= bus_timeout_flag_ff | set_bus_timeout_flag;
      O_TX_KILL <= bus_timeout_flag_ff | set_bus_timeout_flag;
      // R10 no ring status for a missed frame
      O_RING_STATUS_WR_EN <= ~set_miss;
      O_STOP <= stop_ff;
    end
  end
endmodule
`default_nettype wire

// >>> mefs_error_status_chk.sv
// checker for the error-status flag block
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker
module mefs_error_status_chk (
  // clock, reset, host port
  input wire logic I_CLK, input wire logic I_RESETN, input wire logic [1:0] I_REG_SELECT_PORT,
  input wire logic I_REG_WR, input wire logic I_REG_RD, input wire logic [15:0] I_REG_WDATA,
  input wire logic [15:0] O_REG_RDATA,
  // receive events and outputs
  input wire logic I_RX_OVERFLOW, input wire logic I_RX_BUF_OWNED, input wire logic O_IRQ_N,
  input wire logic O_RX_KILL, input wire logic O_TX_KILL, input wire logic O_RING_STATUS_WR_EN,
  input wire logic O_STOP
);
  logic ans;
  logic rej;
  // no reset needed: reads are never issued while reset is low
  always @(posedge I_CLK) begin
    ans <= I_REG_RD && (I_REG_SELECT_PORT == 2'h0);
    rej <= I_REG_RD && (I_REG_SELECT_PORT != 2'h0);
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  property p_err; ans |-> O_REG_RDATA[15] == |O_REG_RDATA[14:11]; endproperty
  a_err: assert property (p_err) else $error("summary bit wrong");
  property p_irq_flag; ans |-> O_REG_RDATA[7] == |{O_REG_RDATA[14], O_REG_RDATA[12:8]}; endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq flag wrong");
  property p_pin; ans |-> O_IRQ_N == !(O_REG_RDATA[7] && O_REG_RDATA[6]); endproperty
  a_pin: assert property (p_pin) else $error("irq pin wrong");
  property p_ref; rej |-> O_REG_RDATA == 16'h0000; endproperty
  a_ref: assert property (p_ref) else $error("other select read");
  property p_ring; I_RX_OVERFLOW && !I_RX_BUF_OWNED |=> !O_RING_STATUS_WR_EN; endproperty
  a_ring: assert property (p_ring) else $error("ring status written");
  property p_kill; ans && O_REG_RDATA[11] |-> ##[0:1] (O_RX_KILL && O_TX_KILL); endproperty
  a_kill: assert property (p_kill) else $error("no shutdown");
  // stop state reaches the pin one cycle after the register takes the write
  property p_stop; I_REG_WR && I_REG_SELECT_PORT == 2'h0 && I_REG_WDATA[2] |-> ##2 O_STOP; endproperty
  a_stop: assert property (p_stop) else $error("stop not set");
  property p_ien; $rose(O_STOP) |=> O_IRQ_N; endproperty
  a_ien: assert property (p_ien) else $error("irq after stop");
  c_tx_babble_flag: cover property (ans && O_REG_RDATA[14]);
  c_ring: cover property (!O_RING_STATUS_WR_EN);
  c_kill: cover property (O_RX_KILL);
endmodule
bind mefs_error_status mefs_error_status_chk u_chk (.I_CLK, .I_RESETN, .I_REG_SELECT_PORT, .I_REG_WR,
  .I_REG_RD, .I_REG_WDATA, .O_REG_RDATA, .I_RX_OVERFLOW, .I_RX_BUF_OWNED, .O_IRQ_N, .O_RX_KILL,
  .O_TX_KILL, .O_RING_STATUS_WR_EN, .O_STOP);
`default_nettype wire

// >>> mefs_partner.sv
// transceiver and bus memory stand-in for the error-status bench
`timescale 1ns/1ps
`default_nettype none
// ====
// partner
module mefs_partner (
  // clock and controller events
  input wire logic clk, input wire logic tx_end, input wire logic strobe,
  // behaviour selects: a dead part never answers
  input wire logic col_on, input wire logic rdy_on,
  // answers
  output logic collision, output logic ready
);
  logic [3:0] tdly = 4'h0;
  logic [3:0] sdly = 4'h0;
  always @(posedge clk) begin
    tdly <= {tdly[2:0], tx_end};
    sdly <= {sdly[2:0], strobe};
  end
  assign collision = col_on & tdly[3];
  assign ready = rdy_on & sdly[3];
endmodule
`default_nettype wire

// >>> tb_mefs_error_status.sv
// self-checking bench for the error-status flag block
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module tb_mefs_error_status;
  logic clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, tb = 1'b0, te = 1'b0, ovf = 1'b0, own = 1'b1;
  logic st = 1'b0, con = 1'b1, ron = 1'b1, col, rdy, irq_n, rk, tk, rw, stp;
  logic [1:0] sel = 2'h0;
  logic [2:0] oi = 3'h0;
  logic [15:0] wd = 16'h0000, rdat;
  int n_fail = 0, n_compared = 0;
  always #25 clk = ~clk;
  mefs_error_status dut_u (.I_CLK(clk), .I_RESETN(rstn), .I_REG_SELECT_PORT(sel), .I_REG_WR(wr_s),
    .I_REG_RD(rd_s), .I_REG_WDATA(wd), .O_REG_RDATA(rdat), .I_RX_INT(oi[2]), .I_TX_INT(oi[1]),
    .I_INIT_DONE(oi[0]), .I_RX_ON(1'b1), .I_TX_ON(1'b1), .I_TX_BYTE(tb), .I_TX_END(te), .I_COLLISION(col),
    .I_RX_OVERFLOW(ovf), .I_RX_BUF_OWNED(own), .I_BUS_ADDR_STROBE(st), .I_BUS_READY(rdy),
    .O_IRQ_N(irq_n), .O_RX_KILL(rk), .O_TX_KILL(tk), .O_RING_STATUS_WR_EN(rw), .O_STOP(stp));
  mefs_partner prt_u (.clk(clk), .tx_end(te), .strobe(st), .col_on(con), .rdy_on(ron), .collision(col),
    .ready(rdy));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    sel <= s;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [1:0] s, input logic [15:0] e);
    @(posedge clk);
    sel <= s;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdat, e);
  endtask
  // k selects the event: 0 end of transmit, 1 silo overflow, 2 address strobe
  task pulse(input int k, input int n);
    @(posedge clk);
    te <= (k == 0);
    ovf <= (k == 1);
    st <= (k == 2);
    @(posedge clk);
    {te, ovf, st} <= 3'h0;
    @(negedge clk);
    chk({15'h0000, rw}, {15'h0000, (k != 1) || own});
    repeat (n) @(posedge clk);
  endtask
  task bytes(input int n);
    @(posedge clk);
    tb <= 1'b1;
    repeat (n) @(posedge clk);
    tb <= 1'b0;
  endtask
  task results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(2'h0, 16'h0034);
    wr(2'h0, 16'h0042);
    bytes(1518);
    rd(2'h0, 16'h0070);
    bytes(1);
    rd(2'h0, 16'hC0F0);
    chk({15'h0000, irq_n}, 16'h0000);
    wr(2'h0, 16'h4040);
    rd(2'h0, 16'h0070);
    pulse(0, 50);
    rd(2'h0, 16'h0070);
    con <= 1'b0;
    pulse(0, 50);
    rd(2'h0, 16'hA070);
    chk({15'h0000, irq_n}, 16'h0001);
    wr(2'h0, 16'h2040);
    rd(2'h0, 16'h0070);
    @(posedge clk);
    oi <= 3'h7;
    rd(2'h0, 16'h07F0);
    chk({15'h0000, irq_n}, 16'h0000);
    @(posedge clk);
    oi <= 3'h0;
    pulse(1, 2);
    rd(2'h0, 16'h0070);
    @(posedge clk);
    own <= 1'b0;
    pulse(1, 2);
    rd(2'h0, 16'h90F0);
    chk({15'h0000, irq_n}, 16'h0000);
    // overflow and write-one clear in one cycle: the flag must stay
    @(posedge clk);
    {wd, wr_s, ovf} <= {16'h1040, 2'h3};
    @(posedge clk);
    {wr_s, ovf} <= 2'h0;
    rd(2'h0, 16'h90F0);
    wr(2'h0, 16'h1040);
    rd(2'h0, 16'h0070);
    pulse(2, 530);
    rd(2'h0, 16'h0070);
    ron <= 1'b0;
    pulse(2, 530);
    rd(2'h0, 16'h88C0);
    chk({14'h0000, rk, tk}, 16'h0003);
    wr(2'h0, 16'h0004);
    rd(2'h0, 16'h0034);
    chk({14'h0000, rk, tk}, 16'h0000);
    chk({15'h0000, stp}, 16'h0001);
    wr(2'h1, 16'h0002);
    rd(2'h0, 16'h0034);
    rd(2'h1, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
